// ### pkg/lp_pkg.sv
/*
 power-state manager package: command codes, states, timing counts and carrier structs.
 assumes a 25 MHz controller clock.
*/
package lp_pkg;
    localparam int NUM_RANKS = 2;
    localparam int CLK_MHZ = 25;
    // exit latency in ns, rounded up to cycles
    localparam int EXIT_LAT_NS = 200;
    localparam int EXIT_LAT_CYC = (EXIT_LAT_NS * CLK_MHZ + 999) / 1000;
    // minimum self-refresh residency before an impedance update exit
    localparam int COMP_HOLD_NS = 400;
    localparam int COMP_HOLD_CYC = (COMP_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] PD_IDLE_RST = 16'h0040;
    localparam logic [TIMER_W-1:0] SR_IDLE_RST = 16'h0400;
    localparam logic [TIMER_W-1:0] REF_INTV_RST = 16'h00c3;
    localparam logic [1:0] PRIO_LIMIT = 2'h2;
    // low-power command codes toward the physical layer
    localparam logic [2:0] PHY_CMD_NONE = 3'h0;
    localparam logic [2:0] PHY_CMD_PD_ACT = 3'h1;
    localparam logic [2:0] PHY_CMD_PD_PRE = 3'h2;
    localparam logic [2:0] PHY_CMD_SR = 3'h3;

    typedef enum logic [4:0] {
        SR_RUN = 5'b00001,
        SR_ENTER = 5'b00010,
        SR_HOLD = 5'b00100,
        SR_EXIT = 5'b01000,
        SR_COMP = 5'b10000
    } sr_state_e;

    // per-rank traffic view from the scheduler
    typedef struct packed {
        logic pending;
        logic issued;
        logic bank_open;
    } rank_req_s;

    // per-rank status back toward the scheduler
    typedef struct packed {
        logic clock_enable;
        logic pd_active;
        logic pd_precharge;
        logic ready;
    } rank_stat_s;
endpackage

// ### design/lp_idle_timer.sv
/*
 idle down-counter: reloads on a restart, reports expiry when it reaches zero.
 assumes the load value is stable while counting.
*/
`timescale 1ns/1ps
`default_nettype none
module lp_idle_timer #(
    parameter int W = 16
) (
    input wire logic i_clk, // controller clock
    input wire logic i_rst, // synchronous reset
    input wire logic i_restart, // reload from i_load
    input wire logic [W-1:0] i_load, // reload value
    output logic o_expired // count has reached zero
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    // count down, hold at zero
    always_comb
    begin
        cnt_next = cnt_reg;
        if (i_restart)
            cnt_next = i_load;
        else if (cnt_reg != '0)
            cnt_next = cnt_reg - 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    // a restart pending this cycle masks expiry so a fresh command never races power-down
    assign o_expired = (cnt_reg == '0) && !i_restart;
endmodule
`default_nettype wire

// ### design/lp_rank_pd.sv
/*
 one rank's power-down control: drops the rank clock enable when idle, raises it and
 waits the exit latency before the scheduler may issue. assumes the top gates it during
 self-refresh and power-up hold.
*/
`timescale 1ns/1ps
`default_nettype none
module lp_rank_pd (
    input wire logic i_clk, // controller clock
    input wire logic i_rst, // synchronous reset
    input wire logic i_allow, // power-down permitted by top
    input wire logic i_force_low, // top holds clock enable low
    input wire logic [lp_pkg::TIMER_W-1:0] i_pd_idle, // idle timer reload
    input wire lp_pkg::rank_req_s i_req, // traffic view
    output lp_pkg::rank_stat_s o_stat // status and clock enable
);
    logic idle_exp;
    logic pd_reg;
    logic pd_next;
    logic pre_reg;
    logic pre_next;
    logic [3:0] wait_reg;
    logic [3:0] wait_next;
    logic cke_reg;
    logic cke_next;

    lp_idle_timer #(.W(lp_pkg::TIMER_W)) u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_restart(i_req.issued | i_req.pending),
        .i_load(i_pd_idle),
        .o_expired(idle_exp)
    );

    // power-down entry and exit sequencing
    always_comb
    begin
        pd_next = pd_reg;
        pre_next = pre_reg;
        wait_next = wait_reg;
        cke_next = cke_reg;
        if (i_force_low)
        begin
            pd_next = 1'b0;
            cke_next = 1'b0;
            wait_next = 4'(lp_pkg::EXIT_LAT_CYC);
        end
        else if (!pd_reg && i_allow && idle_exp && !i_req.pending)
        begin
            // R2 R3 R5: flavour latched from bank state at entry
            pd_next = 1'b1;
            pre_next = !i_req.bank_open;
            // R4: per-rank clock enable dropped
            cke_next = 1'b0;
        end
        else if (pd_reg && (i_req.pending || !i_allow))
        begin
            // R16: wake the rank and start the exit wait
            pd_next = 1'b0;
            cke_next = 1'b1;
            wait_next = 4'(lp_pkg::EXIT_LAT_CYC);
        end
        else if (!pd_reg && !cke_reg)
        begin
            cke_next = 1'b1;
            wait_next = 4'(lp_pkg::EXIT_LAT_CYC);
        end
        else if (wait_reg != 4'h0)
            wait_next = wait_reg - 4'h1;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            pd_reg <= 1'b0;
            pre_reg <= 1'b0;
            wait_reg <= 4'h0;
            cke_reg <= 1'b0;
        end
        else
        begin
            pd_reg <= pd_next;
            pre_reg <= pre_next;
            wait_reg <= wait_next;
            cke_reg <= cke_next;
        end
    end

    assign o_stat.clock_enable = cke_reg;
    assign o_stat.pd_active = pd_reg && !pre_reg;
    assign o_stat.pd_precharge = pd_reg && pre_reg;
    // R16: no issue until clock enable is up and the latency has passed
    // gated by i_allow so an impedance update wake never opens the rank to commands
    assign o_stat.ready = cke_reg && (wait_reg == 4'h0) && !pd_reg && i_allow;

    // R16
    chk_exit_latency: assert property (@(posedge i_clk) disable iff (i_rst) // R16
        $rose(cke_reg) |-> !o_stat.ready [*5])
        else $error("rank ready before exit latency elapsed");
    // R4
    chk_pd_drops_cke: assert property (@(posedge i_clk) disable iff (i_rst) // R4
        pd_reg |-> !cke_reg)
        else $error("rank in power-down with clock enable high");
    // R17
    chk_no_pd_busy: assert property (@(posedge i_clk) disable iff (i_rst) // R17
        (!pd_reg && i_req.issued) |=> !pd_reg)
        else $error("power-down entered right after a command");
endmodule
`default_nettype wire

// ### design/dram_power_state_manager.sv
/*
 memory low-power state manager: per-rank power-down, dynamic and suspend self-refresh,
 impedance update exits, reduced refresh and page close requests.
 assumes a scheduler on the same clock that reports pending traffic and bank state and
 honours the ready, close and refresh outputs; the suspend message arrives on this clock.
*/
// Overview of operation
// R1: power management keeps running whatever the cores' idle state, with no core input.
// R2: an idle rank with an open bank whose timer expired enters active power-down.
// R3: an idle rank with all banks closed whose timer expired enters precharge power-down.
// R4: each rank powers down on its own by dropping its own clock enable bit.
// R5: the power-down flavour is taken from bank state when clock enable drops.
// R6: dynamic self-refresh needs enable, all banks closed, no traffic and an expired timer.
// R7: a request wakes memory from dynamic self-refresh, idle plus timer re-enters it.
// R8: a suspend message puts all memory into self-refresh.
// R9: in self-refresh all outputs but clock enables and reset are disabled.
// R10: a short self-refresh exit and re-entry may run for impedance updates.
// R11: a programmable low-power command selects the physical layer saving mode.
// R12: open pages are closed after idle to save power.
// R13: refresh commands are skipped while memory refreshes itself.
// R14: dynamic self-refresh also needs the upstream priority below two.
// R15: clock enables stay low through power-up until firmware releases them.
// R16: a sleeping rank gets clock enable back and waits the exit latency before commands.
// R17: rank timers restart on commands to the rank, the self-refresh timer on any request.
`timescale 1ns/1ps
`default_nettype none
module dram_power_state_manager #(
    parameter int NR = lp_pkg::NUM_RANKS
) (
    input wire logic I_CLK, // controller clock
    input wire logic I_RST, // synchronous reset
    input wire logic i_CKE_RELEASE, // firmware release of clock enable
    input wire logic i_DYN_SR_EN, // dynamic self-refresh enable
    input wire logic [lp_pkg::TIMER_W-1:0] i_PD_IDLE, // rank idle reload
    input wire logic [lp_pkg::TIMER_W-1:0] i_SR_IDLE, // self-refresh idle reload
    input wire logic [2:0] i_PHY_LP_MODE, // programmed phy low-power mode
    input wire logic i_SUSPEND, // suspend message level
    input wire logic i_COMP_REQ, // impedance update request pulse
    input wire logic i_REQ_ARRIVE, // upstream request arriving
    input wire logic i_QUEUE_BUSY, // command queue not empty
    input wire logic [1:0] i_PRIORITY, // upstream status priority
    input wire lp_pkg::rank_req_s [NR-1:0] i_RANK, // per-rank traffic view
    input wire logic i_DRAM_RESET_REL, // firmware release of dram reset
    output lp_pkg::rank_stat_s [NR-1:0] o_RANK, // per-rank status
    output logic [NR-1:0] o_RANK_CLOCK_ENABLE, // clock enable pins
    output logic o_DRAM_RESET_OUT_N, // dram reset, active low
    output logic o_IO_ENABLE, // other memory outputs enabled
    output logic [2:0] o_PHY_CMD, // low-power command to phy
    output logic o_IN_SELF_REFRESH, // memory in self-refresh
    output logic o_IMPEDANCE_COMP_UPDATE, // impedance update window
    output logic o_CLOSE_PAGES, // page close request
    output logic o_REFRESH_REQ // regular refresh request pulse
);
    lp_pkg::sr_state_e st_reg;
    lp_pkg::sr_state_e st_next;
    logic rel_reg;
    logic rel_next;
    logic rst_n_reg;
    logic rst_n_next;
    logic [2:0] cmd_reg;
    logic [2:0] cmd_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic comp_pend_reg;
    logic comp_pend_next;
    logic [lp_pkg::TIMER_W-1:0] ref_reg;
    logic [lp_pkg::TIMER_W-1:0] ref_next;
    logic ref_out_reg;
    logic ref_out_next;
    logic close_reg;
    logic close_next;
    logic sr_exp;
    logic any_open;
    logic any_pend;
    logic any_busy;
    logic sr_now;
    logic [NR-1:0] rank_cke;
    logic [NR-1:0] pd_act;
    logic [NR-1:0] pd_pre;

    // gather rank-wide conditions
    always_comb
    begin
        any_open = 1'b0;
        any_pend = 1'b0;
        for (int r = 0; r < NR; r++)
        begin
            any_open = any_open | i_RANK[r].bank_open;
            any_pend = any_pend | i_RANK[r].pending;
        end
    end
    assign any_busy = any_pend | i_QUEUE_BUSY | i_REQ_ARRIVE;

    // R17: self-refresh idle timer restarts on any request
    lp_idle_timer #(.W(lp_pkg::TIMER_W)) u_sr_timer (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_restart(any_busy),
        .i_load(i_SR_IDLE),
        .o_expired(sr_exp)
    );

    // one power-down controller per rank
    for (genvar g = 0; g < NR; g++)
    begin : g_rank
        // R10: update window wakes ranks, otherwise the exit would never reach the memory
        lp_rank_pd u_pd (
            .i_clk(I_CLK),
            .i_rst(I_RST),
            .i_allow(st_reg == lp_pkg::SR_RUN),
            .i_force_low(!rel_reg || (st_reg != lp_pkg::SR_RUN && st_reg != lp_pkg::SR_EXIT
                                      && st_reg != lp_pkg::SR_COMP)),
            .i_pd_idle(i_PD_IDLE),
            .i_req(i_RANK[g]),
            .o_stat(o_RANK[g])
        );
        assign rank_cke[g] = o_RANK[g].clock_enable;
        assign pd_act[g] = o_RANK[g].pd_active;
        assign pd_pre[g] = o_RANK[g].pd_precharge;
    end

    // firmware release and dram reset are sticky once given
    always_comb
    begin
        // R15: clock enable stays low until released
        rel_next = rel_reg | i_CKE_RELEASE;
        rst_n_next = rst_n_reg | i_DRAM_RESET_REL;
    end

    // R1: no core state input
    // self-refresh state machine
    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        cmd_next = cmd_reg;
        comp_pend_next = comp_pend_reg | i_COMP_REQ;
        case (st_reg)
            lp_pkg::SR_RUN:
            begin
                // active power-down outranks precharge when ranks differ
                if (|pd_act)
                    cmd_next = lp_pkg::PHY_CMD_PD_ACT;
                else if (|pd_pre)
                    cmd_next = lp_pkg::PHY_CMD_PD_PRE;
                else
                    cmd_next = lp_pkg::PHY_CMD_NONE;
                // R8: suspend forces self-refresh regardless of enable
                if (rel_reg && i_SUSPEND && !any_busy)
                    st_next = lp_pkg::SR_ENTER;
                // R6 R14: dynamic entry conditions
                else if (rel_reg && i_DYN_SR_EN && !any_open && !any_busy && sr_exp
                         && i_PRIORITY < lp_pkg::PRIO_LIMIT)
                    st_next = lp_pkg::SR_ENTER;
            end
            lp_pkg::SR_ENTER:
            begin
                // R11: programmed phy mode sent on entry
                cmd_next = i_PHY_LP_MODE;
                cnt_next = 8'(lp_pkg::COMP_HOLD_CYC);
                st_next = lp_pkg::SR_HOLD;
            end
            lp_pkg::SR_HOLD:
            begin
                if (cnt_reg != 8'h0)
                    cnt_next = cnt_reg - 8'h1;
                // R7: request wakes from dynamic self-refresh, suspend keeps it
                if (!i_SUSPEND && (any_busy || !i_DYN_SR_EN))
                begin
                    st_next = lp_pkg::SR_EXIT;
                    cnt_next = 8'(lp_pkg::EXIT_LAT_CYC);
                end
                // R10: brief exit for impedance update after minimum residency
                else if (comp_pend_reg && cnt_reg == 8'h0)
                begin
                    st_next = lp_pkg::SR_COMP;
                    comp_pend_next = i_COMP_REQ;
                    cnt_next = 8'(lp_pkg::EXIT_LAT_CYC);
                end
            end
            lp_pkg::SR_COMP:
            begin
                cmd_next = lp_pkg::PHY_CMD_NONE;
                if (cnt_reg != 8'h0)
                    cnt_next = cnt_reg - 8'h1;
                else
                    st_next = lp_pkg::SR_ENTER;
            end
            lp_pkg::SR_EXIT:
            begin
                cmd_next = lp_pkg::PHY_CMD_NONE;
                if (cnt_reg != 8'h0)
                    cnt_next = cnt_reg - 8'h1;
                else
                    st_next = lp_pkg::SR_RUN;
            end
            default:
                st_next = lp_pkg::SR_RUN;
        endcase
    end

    // R12: close idle pages once every rank is quiet; R13: skip refresh in self-refresh
    always_comb
    begin
        close_next = any_open && !any_busy && sr_exp && st_reg == lp_pkg::SR_RUN;
        ref_next = ref_reg;
        ref_out_next = 1'b0;
        if (sr_now)
            ref_next = lp_pkg::REF_INTV_RST;
        else if (ref_reg == '0)
        begin
            ref_next = lp_pkg::REF_INTV_RST;
            ref_out_next = rel_reg;
        end
        else
            ref_next = ref_reg - 1'b1;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            st_reg <= lp_pkg::SR_RUN;
            cnt_reg <= 8'h0;
            cmd_reg <= lp_pkg::PHY_CMD_NONE;
            comp_pend_reg <= 1'b0;
            rel_reg <= 1'b0;
            rst_n_reg <= 1'b0;
            ref_reg <= lp_pkg::REF_INTV_RST;
            ref_out_reg <= 1'b0;
            close_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            cmd_reg <= cmd_next;
            comp_pend_reg <= comp_pend_next;
            rel_reg <= rel_next;
            rst_n_reg <= rst_n_next;
            ref_reg <= ref_next;
            ref_out_reg <= ref_out_next;
            close_reg <= close_next;
        end
    end

    // R9: outputs other than clock enable and reset parked during self-refresh
    assign sr_now = (st_reg == lp_pkg::SR_HOLD) || (st_reg == lp_pkg::SR_ENTER);
    assign o_IO_ENABLE = rel_reg && !sr_now && st_reg != lp_pkg::SR_COMP;
    assign o_RANK_CLOCK_ENABLE = rank_cke;
    assign o_DRAM_RESET_OUT_N = rst_n_reg;
    assign o_PHY_CMD = cmd_reg;
    assign o_IN_SELF_REFRESH = sr_now;
    assign o_IMPEDANCE_COMP_UPDATE = (st_reg == lp_pkg::SR_COMP);
    assign o_CLOSE_PAGES = close_reg;
    assign o_REFRESH_REQ = ref_out_reg;

    // R15
    chk_cke_held_low: assert property (@(posedge I_CLK) disable iff (I_RST) // R15
        !rel_reg |-> (rank_cke == '0))
        else $error("clock enable high before firmware release");
    // R9
    chk_io_parked: assert property (@(posedge I_CLK) disable iff (I_RST) // R9
        (sr_now && $past(sr_now)) |-> (!o_IO_ENABLE && rank_cke == '0))
        else $error("memory outputs or clock enable active in self-refresh");
    // R6
    chk_dyn_entry: assert property (@(posedge I_CLK) disable iff (I_RST) // R6
        (st_reg == lp_pkg::SR_RUN && st_next == lp_pkg::SR_ENTER && !i_SUSPEND)
        |-> (i_DYN_SR_EN && !any_open && sr_exp && !any_busy))
        else $error("dynamic self-refresh entered without its conditions");
    // R14
    chk_prio_gate: assert property (@(posedge I_CLK) disable iff (I_RST) // R14
        (st_reg == lp_pkg::SR_RUN && !i_SUSPEND && i_PRIORITY >= lp_pkg::PRIO_LIMIT)
        |=> st_reg != lp_pkg::SR_ENTER)
        else $error("self-refresh entered at high priority");
    // R7
    chk_wake_req: assert property (@(posedge I_CLK) disable iff (I_RST) // R7
        (st_reg == lp_pkg::SR_HOLD && i_REQ_ARRIVE && !i_SUSPEND) |=> st_reg == lp_pkg::SR_EXIT)
        else $error("request did not wake self-refresh");
    // R13
    chk_no_ref_sr: assert property (@(posedge I_CLK) disable iff (I_RST) // R13
        $past(sr_now) |-> !o_REFRESH_REQ)
        else $error("refresh issued during self-refresh");
    // R11
    chk_phy_mode: assert property (@(posedge I_CLK) disable iff (I_RST) // R11
        st_reg == lp_pkg::SR_ENTER |=> o_PHY_CMD == $past(i_PHY_LP_MODE))
        else $error("phy low-power mode not sent on entry");
    // R2
    chk_phy_pd_cmd: assert property (@(posedge I_CLK) disable iff (I_RST) // R2
        (st_reg == lp_pkg::SR_RUN && |pd_act) |=> o_PHY_CMD == lp_pkg::PHY_CMD_PD_ACT)
        else $error("active power-down not reported to phy");
    // R10: update exit runs from residency back to entry
    sequence comp_begin;
        st_reg == lp_pkg::SR_HOLD ##1 st_reg == lp_pkg::SR_COMP;
    endsequence
    chk_comp_exit: assert property (@(posedge I_CLK) disable iff (I_RST) // R10
        comp_begin |-> ##[1:8] st_reg == lp_pkg::SR_ENTER)
        else $error("impedance update exit did not re-enter self-refresh");
    // R10
    chk_comp_cke: assert property (@(posedge I_CLK) disable iff (I_RST) // R10
        (st_reg == lp_pkg::SR_COMP && cnt_reg == 8'h0) |-> rank_cke == '1)
        else $error("clock enable not raised for impedance update");
    // R8
    chk_suspend_hold: assert property (@(posedge I_CLK) disable iff (I_RST) // R8
        (st_reg == lp_pkg::SR_HOLD && i_SUSPEND && !comp_pend_reg) |=> st_reg == lp_pkg::SR_HOLD)
        else $error("suspend self-refresh left early");
    // R13
    chk_ref_pulse: assert property (@(posedge I_CLK) disable iff (I_RST) // R13
        o_REFRESH_REQ |=> !o_REFRESH_REQ)
        else $error("refresh request longer than one cycle");
endmodule
`default_nettype wire

// ### tb/ddr_rank_model.sv
/*
 behavioural model of the memory ranks behind the power-state manager: it counts
 commands that reach a rank whose clock enable has not been back for the exit latency.
 assumes the bench drives the issued strobes in the rank traffic view.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr_rank_model #(
    parameter int NR = 2
) (
    input wire logic i_clk, // controller clock
    input wire logic i_rst, // synchronous reset
    input wire logic [NR-1:0] i_cke, // rank clock enables
    input wire lp_pkg::rank_req_s [NR-1:0] i_req, // commands issued per rank
    output var int o_errors // commands seen too early
);
    int awake_cnt [NR];

    // a sleeping device ignores commands, so an early one is a lost command
    // exit latency
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_errors <= 0;
            for (int r = 0; r < NR; r++)
                awake_cnt[r] <= 0;
        end
        else
        begin
            for (int r = 0; r < NR; r++)
            begin
                if (!i_cke[r])
                    awake_cnt[r] <= 0;
                else if (awake_cnt[r] < 1000)
                    awake_cnt[r] <= awake_cnt[r] + 1;
                if (i_req[r].issued && (!i_cke[r] || awake_cnt[r] < lp_pkg::EXIT_LAT_CYC))
                    o_errors <= o_errors + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/dram_power_state_manager_tb.sv
/*
 self-checking bench for the memory power-state manager: power-up hold, per-rank
 power-down, exit latency, dynamic and suspend self-refresh, impedance update exits.
 assumes the rank model beside it and a 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dram_power_state_manager_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cke_rel = 1'b0;
    logic dram_rel = 1'b0;
    logic dyn_en = 1'b0;
    logic susp = 1'b0;
    logic comp = 1'b0;
    logic arrive = 1'b0;
    logic qbusy = 1'b0;
    logic [15:0] pd_idle = 16'h0008;
    logic [15:0] sr_idle = 16'h0014;
    logic [2:0] lp_mode = 3'h5;
    logic [1:0] prio = 2'h0;
    lp_pkg::rank_req_s [1:0] rank_in = '0;
    lp_pkg::rank_stat_s [1:0] rank_st;
    logic [1:0] cke;
    logic [2:0] phy_cmd;
    logic rst_n, io_en, in_sr, comp_upd, close_pg, ref_req;
    int failures = 0;
    int compares = 0;
    int merr;
    int n;

    // free-running controller clock, 40 ns period
    always #20 clk = ~clk;

    dram_power_state_manager dut (
        .I_CLK(clk), .I_RST(rst), .i_CKE_RELEASE(cke_rel), .i_DYN_SR_EN(dyn_en),
        .i_PD_IDLE(pd_idle), .i_SR_IDLE(sr_idle), .i_PHY_LP_MODE(lp_mode), .i_SUSPEND(susp),
        .i_COMP_REQ(comp), .i_REQ_ARRIVE(arrive), .i_QUEUE_BUSY(qbusy), .i_PRIORITY(prio),
        .i_RANK(rank_in), .i_DRAM_RESET_REL(dram_rel), .o_RANK(rank_st),
        .o_RANK_CLOCK_ENABLE(cke), .o_DRAM_RESET_OUT_N(rst_n), .o_IO_ENABLE(io_en),
        .o_PHY_CMD(phy_cmd), .o_IN_SELF_REFRESH(in_sr), .o_IMPEDANCE_COMP_UPDATE(comp_upd),
        .o_CLOSE_PAGES(close_pg), .o_REFRESH_REQ(ref_req)
    );

    ddr_rank_model #(.NR(2)) ranks (
        .i_clk(clk), .i_rst(rst), .i_cke(cke), .i_req(rank_in), .o_errors(merr)
    );

    // one comparison, four-state exact
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // bounded poll of one status bit, sampled at the falling edge where it is settled
    task automatic wait_until(input string name, input int sel, input logic val, input int lim);
        logic s;
        for (int i = 0; i < lim; i++)
        begin
            @(negedge clk);
            case (sel)
                0: s = cke[0];
                1: s = cke[1];
                2: s = in_sr;
                3: s = rank_st[0].ready;
                4: s = close_pg;
                default: s = comp_upd;
            endcase
            if (s === val)
                return;
        end
        check(name, 16'(s), 16'(val));
    endtask

    // verdict, reached from the test sequence or from the watchdog
    task automatic results();
        $display("checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // watchdog: the sequence needs well under 2000 cycles
    initial
    begin
        repeat (5000) @(negedge clk);
        failures++;
        $display("watchdog expired");
        results();
    end

    initial
    begin
        repeat (6) @(negedge clk);
        check("cke in reset", 16'(cke), 16'h0000);
        check("dram reset in reset", 16'(rst_n), 16'h0000);
        check("io in reset", 16'(io_en), 16'h0000);
        rst = 1'b0;
        rank_in[0].pending = 1'b1;
        rank_in[1].pending = 1'b1;
        repeat (30) @(negedge clk);
        check("cke before release", 16'(cke), 16'h0000);
        $display("test power-up hold done");

        cke_rel = 1'b1;
        dram_rel = 1'b1;
        wait_until("rank0 cke up", 0, 1'b1, 20);
        wait_until("rank1 cke up", 1, 1'b1, 20);
        check("dram reset released", 16'(rst_n), 16'h0001);
        rank_in[0].pending = 1'b0;
        rank_in[0].bank_open = 1'b1;
        wait_until("rank0 active pd", 0, 1'b0, 40);
        check("pd active flag", 16'(rank_st[0].pd_active), 16'h0001);
        check("pd precharge flag", 16'(rank_st[0].pd_precharge), 16'h0000);
        check("rank1 stays up", 16'(cke[1]), 16'h0001);
        $display("test active power-down done");

        // wake rank 0 and issue at the first ready cycle; the model flags an early one
        rank_in[0].pending = 1'b1;
        wait_until("rank0 wake", 0, 1'b1, 10);
        n = 0;
        while (rank_st[0].ready !== 1'b1 && n < 30)
        begin
            @(negedge clk);
            n++;
        end
        check("exit latency kept", 16'(n >= lp_pkg::EXIT_LAT_CYC), 16'h0001);
        rank_in[0].issued = 1'b1;
        @(negedge clk);
        rank_in[0].issued = 1'b0;
        rank_in[0].pending = 1'b0;
        rank_in[0].bank_open = 1'b0;
        wait_until("rank0 precharge pd", 0, 1'b0, 40);
        check("precharge flag", 16'(rank_st[0].pd_precharge), 16'h0001);
        check("active flag off", 16'(rank_st[0].pd_active), 16'h0000);
        $display("test precharge power-down done");

        rank_in[1].pending = 1'b0;
        rank_in[1].bank_open = 1'b1;
        wait_until("pages closed", 4, 1'b1, 80);
        rank_in[1].bank_open = 1'b0;
        dyn_en = 1'b1;
        prio = 2'h2;
        n = 0;
        repeat (200)
        begin
            @(negedge clk);
            n += int'(ref_req === 1'b1);
        end
        check("no sr at priority two", 16'(in_sr), 16'h0000);
        check("refresh while running", 16'(n > 0), 16'h0001);
        prio = 2'h1;
        wait_until("dynamic sr entry", 2, 1'b1, 80);
        repeat (2) @(negedge clk);
        check("cke in sr", 16'(cke), 16'h0000);
        check("io off in sr", 16'(io_en), 16'h0000);
        check("reset kept in sr", 16'(rst_n), 16'h0001);
        check("phy mode in sr", 16'(phy_cmd), 16'(lp_mode));
        n = 0;
        repeat (250)
        begin
            @(negedge clk);
            n += int'(ref_req === 1'b1);
        end
        check("no refresh in sr", 16'(n), 16'h0000);
        $display("test dynamic self-refresh done");

        arrive = 1'b1;
        @(negedge clk);
        arrive = 1'b0;
        wait_until("request wakes", 2, 1'b0, 20);
        wait_until("ready after wake", 3, 1'b1, 30);
        wait_until("re-entry when idle", 2, 1'b1, 80);
        $display("test wake and re-entry done");

        dyn_en = 1'b0;
        arrive = 1'b1;
        wait_until("wake for suspend", 2, 1'b0, 20);
        arrive = 1'b0;
        repeat (40) @(negedge clk);
        check("awake without dynamic", 16'(in_sr), 16'h0000);
        susp = 1'b1;
        wait_until("suspend sr entry", 2, 1'b1, 30);
        arrive = 1'b1;
        repeat (20) @(negedge clk);
        check("suspend holds sr", 16'(in_sr), 16'h0001);
        arrive = 1'b0;
        comp = 1'b1;
        @(negedge clk);
        comp = 1'b0;
        wait_until("impedance window", 5, 1'b1, lp_pkg::COMP_HOLD_CYC + 40);
        wait_until("cke up for update", 0, 1'b1, 4);
        wait_until("impedance window ends", 5, 1'b0, 60);
        wait_until("sr after update", 2, 1'b1, 30);
        check("rank model slips", 16'(merr), 16'h0000);
        susp = 1'b0;
        $display("test suspend self-refresh done");
        results();
    end
endmodule
`default_nettype wire
